// ==== inc/wg_pkg.sv ====
package wg_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DB_W = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] PRIMARY_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] POLARITY_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] RISE_DB_OFS = 3'h2;
  localparam logic [ADDR_W-1:0] FALL_DB_OFS = 3'h3;
  localparam logic [ADDR_W-1:0] FAULT_CTRL_OFS = 3'h4;
  localparam logic [ADDR_W-1:0] FAULT_SEL_OFS = 3'h5;
  localparam logic [ADDR_W-1:0] STEER_OFS = 3'h6;

  // field positions
  localparam int unsigned EN_BIT = 7;
  localparam int unsigned LD_BIT = 6;
  localparam int unsigned IN_BIT = 5;
  localparam int unsigned SD_BIT = 7;
  localparam int unsigned REN_BIT = 6;
  localparam int unsigned OVERRIDE_LEVEL_B_D_LSB = 4;
  localparam int unsigned OVERRIDE_LEVEL_A_C_LSB = 2;
  localparam int unsigned FIXED_LSB = 4;

  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [1:0] OVERRIDE_LEVEL_B_D_RST = 2'h1;
  localparam logic [1:0] OVERRIDE_LEVEL_A_C_RST = 2'h1;
  localparam logic [5:0] SEL_RST = 6'h00;
  localparam logic [3:0] STEER_RST = 4'h0;
  localparam logic [3:0] FIXED_RST = 4'h0;

  // output generation modes
  typedef enum logic [2:0] {
    MODE_STEER_ASYNC = 3'b000,
    MODE_STEER_SYNC = 3'b001,
    MODE_FB_FWD = 3'b010,
    MODE_FB_REV = 3'b011,
    MODE_HALF = 3'b100,
    MODE_PUSH_PULL = 3'b101,
    MODE_RSV_6 = 3'b110,
    MODE_RSV_7 = 3'b111
  } mode_t;

  // override level codes
  localparam logic [1:0] OVR_HIGH = 2'b11;
  localparam logic [1:0] OVR_LOW = 2'b10;
  localparam logic [1:0] OVR_TRI = 2'b01;
  localparam logic [1:0] OVR_INACTIVE = 2'b00;

endpackage

// ==== src/waveform_deadband_steer_shutdown.sv ====
// Summary of operation
// - while disabled, dead-band count writes load the active count at once
// - rising count delays A in half-bridge, B in full-bridge
// - falling count delays B in half-bridge, D in full-bridge
// - when enabled, load request copies buffers at next input falling edge
// - input state shorter than the count gives no pulse on gated output
// - asynchronous input edges vary dead band by at most one clock
// - full-bridge direction bit applies only at next input rising edge
// - direction change: A and C switch at rise, new modulated output delayed once
// - steering: selected outputs follow input, others hold fixed level
// - steering: polarity applies only to selected outputs
// - steering: shutdown overrides only selected outputs
// - mode 000: steering change applies right after the write
// - mode 001: steering change applies at next input rising edge
// - software set of shutdown status forces shutdown, held without auto-restart
// - with auto-restart the status clears itself and output resumes at next rise
// - active selected shutdown input forces override levels at once
// - six shutdown sources, all active low, each individually selectable
// - shutdown sampled by level; cannot clear while a selected source is active
// - A/C and B/D take their own override field, polarity used only by code 00
// - without auto-restart software clear succeeds only with sources inactive
// - overrides stay until first input rising edge after status clears
// - override code 11 high, 10 low, 01 tri-state, 00 polarity inactive
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module waveform_deadband_steer_shutdown
  import wg_pkg::*;
#(
  parameter int unsigned DB_WIDTH = DB_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // selected input waveform, same clock domain
  input wire logic wave_in,
  // shutdown sources, active low
  input wire logic comparator_one_synced_in,
  input wire logic comparator_two_synced_in,
  input wire logic timer_two_postscaled_in,
  input wire logic timer_four_postscaled_in,
  input wire logic timer_six_postscaled_in,
  input wire logic module_input_pin_in,
  // output drive levels and enables
  output logic drive_out_a_out,
  output logic drive_out_b_out,
  output logic drive_out_c_out,
  output logic drive_out_d_out,
  output logic drive_oe_a_out,
  output logic drive_oe_b_out,
  output logic drive_oe_c_out,
  output logic drive_oe_d_out
);

  // decodes a register write at one offset
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // override code to {enable, level}; polarity only enters the inactive code
  function automatic logic [1:0] ovr_drive(input logic [1:0] code, input logic pol);
    unique case (code)
      OVR_HIGH: ovr_drive = 2'b11;
      OVR_LOW: ovr_drive = 2'b10;
      OVR_TRI: ovr_drive = 2'b00;
      OVR_INACTIVE: ovr_drive = {1'b1, pol};
    endcase
  endfunction

  logic en_q;
  mode_t mode_q;
  logic [3:0] pol_q;
  logic ren_q;
  logic [1:0] override_level_b_d_q;
  logic [1:0] override_level_a_c_q;
  logic [5:0] sel_q;
  logic [3:0] steer_buf_q;
  logic [3:0] steer_act_q;
  logic [3:0] fixed_q;
  logic ld_q;
  logic [DB_WIDTH-1:0] dbr_buf_q;
  logic [DB_WIDTH-1:0] dbf_buf_q;
  logic [DB_WIDTH-1:0] dbr_act_q;
  logic [DB_WIDTH-1:0] dbf_act_q;
  logic [DB_WIDTH-1:0] cnt_hi_q;
  logic [DB_WIDTH-1:0] cnt_lo_q;
  logic w_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic sd_q;
  logic hold_q;
  logic dir_q;
  logic first_q;
  logic pp_tog_q;
  logic pp_sel_q;
  logic [3:0] lvl_d;
  logic [3:0] oe_d;
  logic [DATA_W-1:0] rdata_q;
  logic [3:0] drv_q;
  logic [3:0] oe_q;

  logic wr_primary;
  logic wr_fault_ctrl;
  logic rise_ev;
  logic fall_ev;
  logic fault;
  logic ovr_act;
  logic hi_done;
  logic lo_done;
  logic mod_on;
  logic [DB_WIDTH-1:0] fb_db;
  logic fb_mode;
  logic steer_mode;

  assign wr_primary = wr_hit(reg_wr_in, reg_addr_in, PRIMARY_OFS);
  assign wr_fault_ctrl = wr_hit(reg_wr_in, reg_addr_in, FAULT_CTRL_OFS);
  assign fb_mode = (mode_q == MODE_FB_FWD) || (mode_q == MODE_FB_REV);
  assign steer_mode = (mode_q == MODE_STEER_ASYNC) || (mode_q == MODE_STEER_SYNC);

  // input edges, seen one cycle before the registered copy moves
  assign rise_ev = wave_in && !w_q;
  assign fall_ev = !wave_in && w_q;

  // configuration registers written by software
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b0;
      mode_q <= mode_t'(MODE_RST);
      pol_q <= POL_RST;
      ren_q <= 1'b0;
      override_level_b_d_q <= OVERRIDE_LEVEL_B_D_RST;
      override_level_a_c_q <= OVERRIDE_LEVEL_A_C_RST;
      sel_q <= SEL_RST;
      steer_buf_q <= STEER_RST;
      fixed_q <= FIXED_RST;
    end else begin
      if (wr_primary) begin
        en_q <= reg_wdata_in[EN_BIT];
        mode_q <= mode_t'(reg_wdata_in[2:0]);
      end
      if (wr_hit(reg_wr_in, reg_addr_in, POLARITY_OFS)) begin
        pol_q <= reg_wdata_in[3:0];
      end
      if (wr_fault_ctrl) begin
        ren_q <= reg_wdata_in[REN_BIT];
        override_level_b_d_q <= reg_wdata_in[OVERRIDE_LEVEL_B_D_LSB +: 2];
        override_level_a_c_q <= reg_wdata_in[OVERRIDE_LEVEL_A_C_LSB +: 2];
      end
      if (wr_hit(reg_wr_in, reg_addr_in, FAULT_SEL_OFS)) begin
        sel_q <= reg_wdata_in[5:0];
      end
      if (wr_hit(reg_wr_in, reg_addr_in, STEER_OFS)) begin
        steer_buf_q <= reg_wdata_in[3:0];
        fixed_q <= reg_wdata_in[FIXED_LSB +: 4];
      end
    end
  end

  // double-buffered dead-band counts and the self-clearing load request
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbr_buf_q <= '0;
      dbf_buf_q <= '0;
      dbr_act_q <= '0;
      dbf_act_q <= '0;
      ld_q <= 1'b0;
    end else begin
      if (en_q && ld_q && fall_ev) begin
        dbr_act_q <= dbr_buf_q;
        dbf_act_q <= dbf_buf_q;
        ld_q <= 1'b0;
      end
      if (!en_q) begin
        ld_q <= 1'b0;
      end
      // the request only sticks when the module was already running
      if (wr_primary && en_q && reg_wdata_in[EN_BIT] && reg_wdata_in[LD_BIT]) begin
        ld_q <= 1'b1;
      end
      if (wr_hit(reg_wr_in, reg_addr_in, RISE_DB_OFS)) begin
        dbr_buf_q <= reg_wdata_in[DB_WIDTH-1:0];
        if (!en_q) begin
          dbr_act_q <= reg_wdata_in[DB_WIDTH-1:0];
        end
      end
      if (wr_hit(reg_wr_in, reg_addr_in, FALL_DB_OFS)) begin
        dbf_buf_q <= reg_wdata_in[DB_WIDTH-1:0];
        if (!en_q) begin
          dbf_act_q <= reg_wdata_in[DB_WIDTH-1:0];
        end
      end
    end
  end

  // input tracking and saturating dead-band counters per input level
  // counting from the registered input gives a fixed latency, so an input edge that
  // lands anywhere inside a clock period shifts the dead band by under one period
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_q <= 1'b0;
      cnt_hi_q <= '0;
      cnt_lo_q <= '0;
    end else begin
      w_q <= wave_in;
      if (!w_q) begin
        cnt_hi_q <= '0;
      end else if (cnt_hi_q != '1) begin
        cnt_hi_q <= cnt_hi_q + 1'b1;
      end
      if (w_q) begin
        cnt_lo_q <= '0;
      end else if (cnt_lo_q != '1) begin
        cnt_lo_q <= cnt_lo_q + 1'b1;
      end
    end
  end

  // a level that ends before its count finishes never asserts the gated output
  assign hi_done = w_q && (cnt_hi_q >= dbr_act_q);
  assign lo_done = !w_q && (cnt_lo_q >= dbf_act_q);

  // module pin is asynchronous: two flops before any logic looks at it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= module_input_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // any selected low source is a fault, judged by level every cycle
  assign fault = |(sel_q & ~{pin_s2_q, timer_six_postscaled_in, timer_four_postscaled_in,
                             timer_two_postscaled_in, comparator_two_synced_in,
                             comparator_one_synced_in});

  // shutdown status: hardware set wins over any clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sd_q <= 1'b0;
    end else if (fault) begin
      sd_q <= 1'b1;
    end else if (wr_fault_ctrl) begin
      sd_q <= reg_wdata_in[SD_BIT];
    end else if (ren_q) begin
      sd_q <= 1'b0;
    end
  end

  // overrides outlive the status until the next input rising edge
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_q <= 1'b0;
    end else if (sd_q || fault) begin
      hold_q <= 1'b1;
    end else if (rise_ev) begin
      hold_q <= 1'b0;
    end
  end

  // the fault term enters directly so the very next edge shows the override
  assign ovr_act = fault || sd_q || hold_q;

  // full-bridge direction and one-shot dead band after a reversal
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q <= 1'b0;
      first_q <= 1'b0;
    end else if (!fb_mode) begin
      dir_q <= mode_q[0];
      first_q <= 1'b0;
    end else if (rise_ev) begin
      dir_q <= mode_q[0];
      first_q <= (mode_q[0] != dir_q);
    end else if (fall_ev) begin
      first_q <= 1'b0;
    end
  end

  // reverse delays B by the rising count, forward delays D by the falling count
  assign fb_db = dir_q ? dbr_act_q : dbf_act_q;
  assign mod_on = w_q && (!first_q || (cnt_hi_q >= fb_db));

  // push-pull sequencer restarts on A after disable or shutdown
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pp_tog_q <= 1'b0;
      pp_sel_q <= 1'b0;
    end else if (!en_q || ovr_act) begin
      pp_tog_q <= 1'b0;
      pp_sel_q <= 1'b0;
    end else if (rise_ev) begin
      pp_sel_q <= pp_tog_q;
      pp_tog_q <= !pp_tog_q;
    end
  end

  // active steering selection, immediate or on the next input rise
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      steer_act_q <= STEER_RST;
    end else if (mode_q == MODE_STEER_ASYNC) begin
      if (wr_hit(reg_wr_in, reg_addr_in, STEER_OFS)) begin
        steer_act_q <= reg_wdata_in[3:0];
      end else begin
        steer_act_q <= steer_buf_q;
      end
    end else if (rise_ev) begin
      steer_act_q <= steer_buf_q;
    end
  end

  // output selection: mode waveform, then override, then module enable
  always_comb begin
    logic [3:0] raw;
    logic [3:0] mask;
    logic [1:0] ov;
    raw = 4'h0;
    mask = 4'hf;
    ov = 2'b00;
    lvl_d = 4'h0;
    oe_d = 4'h0;
    unique case (mode_q)
      MODE_STEER_ASYNC, MODE_STEER_SYNC: begin
        raw = {4{w_q}};
        mask = steer_act_q;
      end
      MODE_FB_FWD, MODE_FB_REV: begin
        raw = dir_q ? {1'b0, 1'b1, mod_on, 1'b0} : {mod_on, 1'b0, 1'b0, 1'b1};
      end
      MODE_HALF: begin
        raw = {lo_done, hi_done, lo_done, hi_done};
      end
      MODE_PUSH_PULL: begin
        raw = {w_q && pp_sel_q, w_q && !pp_sel_q, w_q && pp_sel_q, w_q && !pp_sel_q};
      end
      MODE_RSV_6, MODE_RSV_7: begin
        raw = 4'h0;
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (steer_mode && !steer_act_q[i]) begin
        lvl_d[i] = fixed_q[i];
      end else begin
        lvl_d[i] = raw[i] ^ pol_q[i];
      end
      oe_d[i] = 1'b1;
      if (ovr_act && mask[i]) begin
        ov = ovr_drive((i % 2 == 0) ? override_level_a_c_q : override_level_b_d_q, pol_q[i]);
        oe_d[i] = ov[1];
        lvl_d[i] = ov[0];
      end
      if (!en_q) begin
        oe_d[i] = 1'b0;
        lvl_d[i] = 1'b0;
      end
    end
  end

  // output flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      drv_q <= lvl_d;
      oe_q <= oe_d;
    end
  end

  assign drive_out_a_out = drv_q[0];
  assign drive_out_b_out = drv_q[1];
  assign drive_out_c_out = drv_q[2];
  assign drive_out_d_out = drv_q[3];
  assign drive_oe_a_out = oe_q[0];
  assign drive_oe_b_out = oe_q[1];
  assign drive_oe_c_out = oe_q[2];
  assign drive_oe_d_out = oe_q[3];

  // read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd_in) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_in)
        PRIMARY_OFS: rdata_q <= {en_q, ld_q, 3'b000, mode_q};
        POLARITY_OFS: rdata_q <= {2'b00, w_q, 1'b0, pol_q};
        RISE_DB_OFS: rdata_q <= 8'(dbr_buf_q);
        FALL_DB_OFS: rdata_q <= 8'(dbf_buf_q);
        FAULT_CTRL_OFS: rdata_q <= {sd_q, ren_q, override_level_b_d_q, override_level_a_c_q, 2'b00};
        FAULT_SEL_OFS: rdata_q <= {2'b00, sel_q};
        STEER_OFS: rdata_q <= {fixed_q, steer_buf_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_db_direct_load;
    !en_q && wr_hit(reg_wr_in, reg_addr_in, RISE_DB_OFS) |=> dbr_act_q == $past(reg_wdata_in[DB_WIDTH-1:0]);
  endproperty
  a_db_direct_load: assert property (p_db_direct_load) else $error("rising count not loaded at once");

  property p_ld_copy;
    en_q && ld_q && fall_ev |=> (dbf_act_q == $past(dbf_buf_q)) && (dbr_act_q == $past(dbr_buf_q));
  endproperty
  a_ld_copy: assert property (p_ld_copy) else $error("buffered counts not copied on falling edge");

  property p_ld_self_clear;
    en_q && ld_q && fall_ev && !wr_primary |=> !ld_q;
  endproperty
  a_ld_self_clear: assert property (p_ld_self_clear) else $error("load request did not clear");

  property p_half_a_deadband;
    en_q && mode_q == MODE_HALF && !ovr_act && w_q && cnt_hi_q < dbr_act_q |=> drive_out_a_out == pol_q[0];
  endproperty
  a_half_a_deadband: assert property (p_half_a_deadband) else $error("output a active inside dead band");

  property p_half_b_deadband;
    en_q && mode_q == MODE_HALF && !ovr_act && !w_q && cnt_lo_q < dbf_act_q |=> drive_out_b_out == pol_q[1];
  endproperty
  a_half_b_deadband: assert property (p_half_b_deadband) else $error("output b active inside dead band");

  property p_dir_hold;
    fb_mode && !rise_ev ##1 fb_mode |-> $stable(dir_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed away from a rising edge");

  property p_steer_async;
    mode_q == MODE_STEER_ASYNC && wr_hit(reg_wr_in, reg_addr_in, STEER_OFS) |=> steer_act_q == $past(reg_wdata_in[3:0]);
  endproperty
  a_steer_async: assert property (p_steer_async) else $error("async steering not immediate");

  property p_steer_sync;
    mode_q == MODE_STEER_SYNC && !rise_ev |=> $stable(steer_act_q);
  endproperty
  a_steer_sync: assert property (p_steer_sync) else $error("sync steering changed off a rising edge");

  property p_fault_low;
    en_q && fault && override_level_a_c_q == OVR_LOW && !steer_mode |=> drive_oe_a_out && !drive_out_a_out;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault did not force override on a");

  property p_sd_held;
    sd_q && fault && !ren_q |=> sd_q;
  endproperty
  a_sd_held: assert property (p_sd_held) else $error("shutdown cleared while source active");

  property p_auto_clear;
    sd_q && ren_q && !fault && !wr_fault_ctrl |=> !sd_q;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto-restart did not clear shutdown");

  property p_hold_until_rise;
    hold_q && !sd_q && !fault && !rise_ev |=> hold_q;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) else $error("override released before rising edge");

  c_ld_copy: cover property (en_q && ld_q && fall_ev);
  c_reverse: cover property (fb_mode && rise_ev && mode_q[0] != dir_q);
  c_restart: cover property (hold_q && !sd_q && rise_ev);

endmodule

`default_nettype wire

// ==== test/power_stage_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module power_stage_model (
  // clock and pacing from the bench
  input wire logic mclk_in,
  input wire logic run_in,
  input wire logic [7:0] hi_len_in,
  input wire logic [7:0] lo_len_in,
  // pwm source feeding the generator
  output logic wave_out,
  // gate drivers of the switch stage
  input wire logic [3:0] level_in,
  input wire logic [3:0] oe_in,
  output logic [3:0] gate_out
);
  logic wave_q;
  logic [7:0] cnt_q;

  // pwm source; stopped means low, so no stray rising event reaches the generator
  always_ff @(posedge mclk_in) begin
    if (!run_in) begin
      wave_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q + 8'h01 >= (wave_q ? hi_len_in : lo_len_in)) begin
      wave_q <= !wave_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign wave_out = run_in & wave_q;

  // a released gate driver is pulled down, so a tri-stated output keeps its switch off
  assign gate_out = oe_in & level_in;
endmodule

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb import wg_pkg::*;;
  // bench state
  logic clk, rst_n, wr_s, rd_s, wave, run;
  logic [2:0] addr;
  logic [7:0] wd, rdata, hi;
  logic [5:0] flt_n;
  logic [3:0] lv, oe, gate, eoe, egt;
  logic [1:0] cd, e;
  int n_errors, checked, n, k, i;

  waveform_deadband_steer_shutdown waveform_deadband_steer_shutdown_i (
    .mclk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .wave_in(wave),
    .comparator_one_synced_in(flt_n[0]), .comparator_two_synced_in(flt_n[1]),
    .timer_two_postscaled_in(flt_n[2]), .timer_four_postscaled_in(flt_n[3]),
    .timer_six_postscaled_in(flt_n[4]), .module_input_pin_in(flt_n[5]),
    .drive_out_a_out(lv[0]), .drive_out_b_out(lv[1]), .drive_out_c_out(lv[2]),
    .drive_out_d_out(lv[3]), .drive_oe_a_out(oe[0]), .drive_oe_b_out(oe[1]),
    .drive_oe_c_out(oe[2]), .drive_oe_d_out(oe[3]));

  power_stage_model power_stage_model_i (
    .mclk_in(clk), .run_in(run), .hi_len_in(hi), .lo_len_in(8'h0a),
    .wave_out(wave), .level_in(lv), .oe_in(oe), .gate_out(gate));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  // sample one nanosecond after the edge so its updates have landed
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", rdata, x);
  endtask

  // cycles from the edge that first samples a wave edge to output idx going high
  task automatic meas(input logic dir, input int idx);
    logic p;
    repeat (300) begin
      p = wave;
      step(1);
      if (wave === dir && p !== dir) break;
    end
    n = 0;
    repeat (300) begin
      step(1);
      if (lv[idx] === 1'b1) break;
      n++;
    end
  endtask

  // hang guard, 20000 cycles, far beyond the well under one thousand cycles the sequence needs
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 3'h0;
    wd = 8'h00;
    run = 1'b0;
    hi = 8'h0a;
    flt_n = 6'h3f;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(FAULT_CTRL_OFS, 8'h14);
    rdc(3'h7, 8'h00);
    wr(RISE_DB_OFS, 8'h02);
    wr(FALL_DB_OFS, 8'h03);
    rdc(RISE_DB_OFS, 8'h02);
    wr(PRIMARY_OFS, 8'h04);
    wr(FAULT_CTRL_OFS, 8'hb8);
    wr(PRIMARY_OFS, 8'h84);
    step(3);
    chk("lv", lv, 4'ha);
    chk("oe", oe, 4'hf);
    wr(FAULT_CTRL_OFS, 8'h38);
    run <= 1'b1;
    step(25);
    meas(1'b1, 0);
    chk("a delay", n[7:0], 8'h03);
    meas(1'b0, 1);
    chk("b delay", n[7:0], 8'h04);
    wr(RISE_DB_OFS, 8'h06);
    meas(1'b1, 0);
    chk("a delay", n[7:0], 8'h03);
    wr(PRIMARY_OFS, 8'hc4);
    step(30);
    rdc(PRIMARY_OFS, 8'h84);
    meas(1'b1, 0);
    chk("a delay", n[7:0], 8'h07);
    // high time shorter than the rising count
    hi <= 8'h03;
    step(20);
    n = 0;
    repeat (60) begin
      step(1);
      if (lv[0] === 1'b1) n++;
    end
    chk("a pulses", n[7:0], 8'h00);
    hi <= 8'h0a;
    // every source alone; the pin passes two extra flops
    for (i = 0; i < 6; i++) begin
      wr(FAULT_SEL_OFS, 8'h01 << i);
      flt_n[i] <= 1'b0;
      step(i == 5 ? 3 : 1);
      chk("lv", lv, 4'ha);
      wr(FAULT_CTRL_OFS, 8'h38);
      rdc(FAULT_CTRL_OFS, 8'hb8);
      flt_n[i] <= 1'b1;
      step(4);
      wr(FAULT_CTRL_OFS, 8'h38);
      rdc(FAULT_CTRL_OFS, 8'h38);
    end
    run <= 1'b0;
    wr(FAULT_CTRL_OFS, 8'hbc);
    step(20);
    rdc(FAULT_CTRL_OFS, 8'hbc);
    wr(FAULT_CTRL_OFS, 8'h3c);
    step(10);
    chk("lv", lv, 4'hf);
    run <= 1'b1;
    step(40);
    meas(1'b1, 0);
    chk("a delay", n[7:0], 8'h07);
    wr(FAULT_CTRL_OFS, 8'hf8);
    step(3);
    rdc(FAULT_CTRL_OFS, 8'h78);
    wr(FAULT_CTRL_OFS, 8'h38);
    run <= 1'b0;
    // all four override codes, with polarity set on a and c
    wr(POLARITY_OFS, 8'h05);
    for (k = 0; k < 4; k++) begin
      wr(FAULT_CTRL_OFS, {2'b10, 2'(3 - k), 2'(k), 2'b00});
      for (i = 0; i < 4; i++) begin
        cd = i[0] ? 2'(3 - k) : 2'(k);
        e = cd == OVR_HIGH ? 2'b11 : cd == OVR_LOW ? 2'b10 : cd == OVR_TRI ? 2'b00 : {1'b1, !i[0]};
        eoe[i] = e[1];
        egt[i] = e[0];
      end
      step(3);
      chk("oe", oe, eoe);
      chk("gate", gate, egt);
    end
    wr(POLARITY_OFS, 8'h03);
    wr(FAULT_CTRL_OFS, 8'h38);
    run <= 1'b1;
    step(30);
    run <= 1'b0;
    // steering with the wave held low
    wr(PRIMARY_OFS, 8'h80);
    wr(STEER_OFS, 8'ha1);
    step(3);
    chk("lv", lv, 4'hb);
    wr(POLARITY_OFS, 8'h01);
    wr(STEER_OFS, 8'ha3);
    step(2);
    chk("lv", lv, 4'h9);
    wr(FAULT_CTRL_OFS, 8'ha8);
    step(2);
    chk("lv", lv, 4'h8);
    wr(FAULT_CTRL_OFS, 8'h38);
    run <= 1'b1;
    step(30);
    run <= 1'b0;
    wr(PRIMARY_OFS, 8'h81);
    wr(STEER_OFS, 8'ha1);
    step(5);
    chk("lv", lv, 4'h9);
    run <= 1'b1;
    step(25);
    run <= 1'b0;
    step(3);
    chk("lv", lv, 4'hb);
    // full bridge, direction flipped in mid-pulse
    wr(POLARITY_OFS, 8'h00);
    wr(PRIMARY_OFS, 8'h82);
    run <= 1'b1;
    step(40);
    meas(1'b1, 3);
    chk("d delay", n[7:0], 8'h01);
    wr(PRIMARY_OFS, 8'h83);
    step(2);
    chk("a", {7'h00, lv[0]}, 8'h01);
    meas(1'b1, 1);
    chk("b delay", n[7:0], 8'h07);
    chk("a c", {6'h00, lv[2], lv[0]}, 8'h02);
    meas(1'b1, 1);
    chk("b delay", n[7:0], 8'h01);
    end_sim();
  end
endmodule

`default_nettype wire
